// [pmc_registers.sv]
`timescale 1ns/1ps
`default_nettype none

module pmc_registers
  import pmc_pkg::*;
#(
  parameter int       FREEZE_SHORT = FREEZE_SHORT_CYCLES,
  parameter int       FREEZE_LONG  = FREEZE_LONG_CYCLES,
  parameter bit [0:0] REVISION_BIT = 1'b0  // Revision marker; the value is arbitrary.
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_write_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_read_in,
  output var  logic [15:0] reg_rdata_out,
  input  wire logic        diag_done_in,
  input  wire logic        first_echo_polarity_in,
  input  wire logic        cross_reflection_flag_in,
  input  wire logic        master_mode_in,
  input  wire logic        ref_clock_out_50m_in,
  input  wire logic        second_link_led_in,
  input  wire logic        wake_indication_in,
  input  wire logic        management_interrupt_in,
  input  wire logic        ref_clock_out_25m_in,
  input  wire logic        first_led_general_output_in,
  input  wire logic        first_led_pin_control_in,
  input  wire logic        receive_disabled_in,
  input  wire logic        settled_state_in,
  input  wire logic        idle_wake_state_in,
  input  wire logic        idle_wait_state_in,
  input  wire logic        idle_hold_state_in,
  input  wire logic        idle_refresh_start_in,
  output var  logic        second_pin_out,
  output var  logic        ref_clock_pin_out,
  output var  logic        ref_clock_pin_oe_out,
  output var  logic [1:0]  mac_pad_series_termination_out,
  output var  logic        ref_clock_out_disable_out,
  output var  logic        rmii_rx_clk_sel_out,
  output var  logic        freeze_all_loops_out,
  output var  logic        mse_check_bypass_out,
  output var  logic        settled_freeze_out,
  output var  logic        refresh_freeze_out,
  output var  logic [5:0]  wait_loop_freeze_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [15:0] pin_io_configuration;
  logic [15:0] spare_loop_control;
  logic [15:0] echo_polarity_cross_result;

  wire hit_pin_io = (reg_addr_in == REG_PIN_IO_CONFIG);
  wire hit_spare  = (reg_addr_in == REG_SPARE_LOOP_CTRL);
  wire hit_echo   = (reg_addr_in == REG_ECHO_POL_CROSS);
  wire hit_amp    = (reg_addr_in == REG_ECHO_AMP_FIVE);

  wire [15:0] next_pin_io = (reg_wdata_in & PIN_IO_WRITE_MASK);
  wire [15:0] next_spare  = (reg_wdata_in & SPARE_WRITE_MASK);

  wire        ref_clock_out_disable = pin_io_configuration[POS_REF_CLK_OFF];
  wire [2:0]  second_pin_function_select =
    pin_io_configuration[POS_PIN2_SEL_HI:POS_PIN2_SEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes.

  wire write_pin_io = reg_write_in & hit_pin_io;
  wire write_spare  = reg_write_in & hit_spare;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_io_configuration <= PIN_IO_RESET;
    end else if (write_pin_io) begin
      pin_io_configuration <= next_pin_io;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      spare_loop_control <= SPARE_RESET;
    end else if (write_spare) begin
      spare_loop_control <= next_spare;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic result capture.

  wire [15:0] next_echo = ECHO_RESET
                        | (16'(first_echo_polarity_in) << POS_FIRST_ECHO_POLARITY)
                        | (16'(cross_reflection_flag_in) << POS_CROSS_REFLECTION);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      echo_polarity_cross_result <= ECHO_RESET;
    end else if (diag_done_in) begin
      echo_polarity_cross_result <= next_echo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  wire [15:0] spare_view = spare_loop_control
                         | (16'(REVISION_BIT) << POS_REVISION)
                         | (16'(ref_clock_out_disable) << POS_CLK_OFF_STATUS);

  wire [15:0] read_mux = hit_pin_io ? pin_io_configuration :
                         hit_spare  ? spare_view :
                         hit_echo   ? echo_polarity_cross_result :
                         hit_amp    ? 16'h0000 : 16'h0000;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
      reg_rdata_out <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin functions.

  logic next_second_pin;

  always_comb begin
    case (second_pin_function_select)
      PIN2_REF_CLK_50M: next_second_pin = master_mode_in & ref_clock_out_50m_in;
      PIN2_LINK_LED:    next_second_pin = second_link_led_in;
      PIN2_WAKE:        next_second_pin = wake_indication_in;
      PIN2_MGMT_INT:    next_second_pin = management_interrupt_in;
      PIN2_CONST_ONE:   next_second_pin = 1'b1;
      default:          next_second_pin = 1'b0;
    endcase
  end

  // clock or LED on 25 MHz pin
  wire next_ref_pin = ref_clock_out_disable ? first_led_general_output_in
                                            : ref_clock_out_25m_in;
  wire next_ref_oe  = ref_clock_out_disable ? first_led_pin_control_in : 1'b1;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      second_pin_out <= 1'b0;
    end else begin
      second_pin_out <= next_second_pin;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ref_clock_pin_out <= 1'b0;
    end else begin
      ref_clock_pin_out <= next_ref_pin;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ref_clock_pin_oe_out <= 1'b0;
    end else begin
      ref_clock_pin_oe_out <= next_ref_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop controls.

  wire [1:0] mac_pad_series_termination = pin_io_configuration[POS_TERM_HI:POS_TERM_LO];
  wire       rmii_rx_clk_sel   = spare_loop_control[POS_RMII_RX_CLK_SEL];
  wire       freeze_all_en     = spare_loop_control[POS_FREEZE_ON_RX_DIS];
  wire       freeze_all        = freeze_all_en & receive_disabled_in;
  wire       mse_bypass_en     = spare_loop_control[POS_MSE_BYPASS_WAKE];
  wire       mse_bypass        = mse_bypass_en & idle_wake_state_in;
  wire       settled_freeze_en = spare_loop_control[POS_SETTLED_FREEZE];
  wire       settled_freeze    = settled_freeze_en & settled_state_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mac_pad_series_termination_out <= TERM_50_OHM;
    end else begin
      mac_pad_series_termination_out <= mac_pad_series_termination;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ref_clock_out_disable_out <= 1'b0;
    end else begin
      ref_clock_out_disable_out <= ref_clock_out_disable;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rmii_rx_clk_sel_out <= 1'b0;
    end else begin
      rmii_rx_clk_sel_out <= rmii_rx_clk_sel;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      freeze_all_loops_out <= 1'b0;
    end else begin
      freeze_all_loops_out <= freeze_all;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mse_check_bypass_out <= 1'b0;
    end else begin
      mse_check_bypass_out <= mse_bypass;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      settled_freeze_out <= 1'b0;
    end else begin
      settled_freeze_out <= settled_freeze;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-loop wait freezes.

  wire [5:0] wait_freeze_en = spare_loop_control[POS_WAIT_FREEZE_LO +: WAIT_FREEZE_COUNT];
  genvar g;
  generate
    for (g = 0; g < WAIT_FREEZE_COUNT; g++) begin : g_wait_freeze
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          wait_loop_freeze_out[g] <= 1'b0;
        end else begin
          wait_loop_freeze_out[g] <= wait_freeze_en[g] & idle_wait_state_in;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Counted refresh freeze.

  logic timer_busy;
  wire  timer_enable   = spare_loop_control[POS_COUNTER_FREEZE_EN];
  wire  timer_start    = idle_refresh_start_in & idle_hold_state_in;
  wire  timer_long_sel = spare_loop_control[POS_FREEZE_TIMER_SEL];

  pmc_freeze_timer #(
    .SHORT_CYCLES (FREEZE_SHORT),
    .LONG_CYCLES  (FREEZE_LONG),
    .WIDTH        (16)
  ) u_freeze_timer (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .enable_in   (timer_enable),
    .start_in    (timer_start),
    .long_sel_in (timer_long_sel),
    .busy_out    (timer_busy)
  );

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      refresh_freeze_out <= 1'b0;
    end else begin
      refresh_freeze_out <= timer_busy;
    end
  end

endmodule

`default_nettype wire

// [pmc_pkg.sv]
package pmc_pkg;

  localparam logic [15:0] REG_ECHO_AMP_FIVE    = 16'h0189;
  localparam logic [15:0] REG_ECHO_POL_CROSS   = 16'h018a;
  localparam logic [15:0] REG_PIN_IO_CONFIG    = 16'h0302;
  localparam logic [15:0] REG_SPARE_LOOP_CTRL  = 16'h0308;

  localparam int POS_FIRST_ECHO_POLARITY = 11;
  localparam int POS_CROSS_REFLECTION    = 5;

  localparam int POS_TERM_HI             = 15;
  localparam int POS_TERM_LO             = 14;
  localparam int POS_REF_CLK_OFF         = 6;
  localparam int POS_PIN2_SEL_HI         = 2;
  localparam int POS_PIN2_SEL_LO         = 0;

  localparam int POS_CLK_OFF_STATUS      = 0;
  localparam int POS_REVISION            = 1;
  localparam int POS_RMII_RX_CLK_SEL     = 2;
  localparam int POS_FREEZE_ON_RX_DIS    = 4;
  localparam int POS_MSE_BYPASS_WAKE     = 5;
  localparam int POS_SETTLED_FREEZE      = 6;
  localparam int POS_COUNTER_FREEZE_EN   = 7;
  localparam int POS_FREEZE_TIMER_SEL    = 8;
  localparam int POS_WAIT_FREEZE_LO      = 10;
  localparam int WAIT_FREEZE_COUNT       = 6;

  localparam logic [15:0] PIN_IO_WRITE_MASK = 16'hc047;
  localparam logic [15:0] SPARE_WRITE_MASK  = 16'hfffc;
  localparam logic [15:0] PIN_IO_RESET      = 16'h0000;
  localparam logic [15:0] SPARE_RESET       = 16'h0000;
  localparam logic [15:0] ECHO_RESET        = 16'h0000;

  localparam logic [2:0] PIN2_REF_CLK_50M  = 3'h0;
  localparam logic [2:0] PIN2_LINK_LED     = 3'h1;
  localparam logic [2:0] PIN2_WAKE         = 3'h2;
  localparam logic [2:0] PIN2_MGMT_INT     = 3'h4;
  localparam logic [2:0] PIN2_CONST_ONE    = 3'h6;

  localparam logic [1:0] TERM_50_OHM = 2'h0;
  localparam logic [1:0] TERM_25_OHM = 2'h1;

  localparam int CLOCK_PERIOD_PS      = 8000;
  localparam int FREEZE_SHORT_US      = 176;
  localparam int FREEZE_LONG_US       = 192;
  localparam int FREEZE_SHORT_CYCLES  = (FREEZE_SHORT_US * 1000000) / CLOCK_PERIOD_PS;
  localparam int FREEZE_LONG_CYCLES   = (FREEZE_LONG_US * 1000000) / CLOCK_PERIOD_PS;

endpackage

// [pmc_freeze_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module pmc_freeze_timer #(
  parameter int SHORT_CYCLES = 22000,
  parameter int LONG_CYCLES  = 24000,
  parameter int WIDTH        = 16
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic start_in,
  input  wire logic long_sel_in,
  output var  logic busy_out
);

  logic [WIDTH-1:0] remaining;
  logic [WIDTH-1:0] next_remaining;
  wire  [WIDTH-1:0] load_value = long_sel_in ? WIDTH'(LONG_CYCLES) : WIDTH'(SHORT_CYCLES);
  wire              counting   = (remaining != '0);

  always_comb begin
    next_remaining = remaining;
    if (!enable_in) begin
      next_remaining = '0;
    end else if (start_in) begin
      next_remaining = load_value;
    end else if (counting) begin
      next_remaining = remaining - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      remaining <= '0;
      busy_out  <= 1'b0;
    end else begin
      remaining <= next_remaining;
      busy_out  <= (next_remaining != '0);
    end
  end

endmodule

`default_nettype wire

// [pmc_registers_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module pmc_monitor
  import pmc_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_write_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        receive_disabled_in,
  input wire logic        second_pin_out,
  input wire logic        ref_clock_pin_oe_out,
  input wire logic [1:0]  mac_pad_series_termination_out,
  input wire logic        ref_clock_out_disable_out,
  input wire logic        freeze_all_loops_out,
  input wire logic        refresh_freeze_out
);
  wire io_wr = reg_write_in && reg_addr_in == REG_PIN_IO_CONFIG;
  wire rd_nul = reg_read_in && !(reg_addr_in inside {REG_ECHO_POL_CROSS, REG_PIN_IO_CONFIG,
    REG_SPARE_LOOP_CTRL});
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////////
  // termination follows write.
  a_term_follows: assert property (io_wr |-> ##2
    mac_pad_series_termination_out == $past(reg_wdata_in[15:14], 2)) else $error("bad term");
  a_clock_off: assert property (io_wr |-> ##2 ref_clock_out_disable_out ==
    $past(reg_wdata_in[6], 2) && (ref_clock_out_disable_out || ref_clock_pin_oe_out))
    else $error("bad clock pin");
  a_pin_one: assert property (io_wr && reg_wdata_in[2:0] == 3'h6 |-> ##2 second_pin_out)
    else $error("pin not one");
  a_pin_zero: assert property (io_wr && reg_wdata_in[2:0] inside {3'h3, 3'h5, 3'h7}
    |-> ##2 !second_pin_out) else $error("pin not zero");
  a_rdata_holds: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  a_unmapped_zero: assert property (rd_nul |=> reg_rdata_out == 16'h0000)
    else $error("unmapped not zero");
  a_io_reserved: assert property (reg_read_in && reg_addr_in == REG_PIN_IO_CONFIG |=>
    (reg_rdata_out & ~PIN_IO_WRITE_MASK) == 16'h0000) else $error("reserved set");
  a_freeze_cause: assert property (freeze_all_loops_out |-> $past(receive_disabled_in))
    else $error("freeze without cause");
  c_refresh: cover property ($rose(refresh_freeze_out));
  c_io_write: cover property (io_wr);
  c_null_read: cover property (rd_nul);
endmodule
bind pmc_registers pmc_monitor mon (.*);
`default_nettype wire

// [phy_misc_config_registers_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_misc_config_registers_tb;
  logic clk_in = 0, reset_in = 1, wr = 0, rd = 0, diag = 0, pol = 0, crs = 0, mst = 1, c50 = 0;
  logic led2 = 0, wake = 0, mint = 0, c25 = 0, led1 = 0, pctl = 0, rxd = 0, stl = 0, iwk = 0;
  logic iwt = 0, ihd = 0, rfs = 0, sp, rp, roe, cko, rsel, fal, mse, sfz, rfz;
  logic [15:0] addr = 0, wdata = 0, rdata;
  logic [1:0] term;
  logic [5:0] wfz;
  logic [3:0] oh;
  int n_mismatch = 0, check_count = 0, n;
  pmc_registers #(.FREEZE_SHORT(20), .FREEZE_LONG(30)) dut (.clk_in(clk_in),
    .reset_in(reset_in), .reg_addr_in(addr), .reg_write_in(wr), .reg_wdata_in(wdata),
    .reg_read_in(rd), .reg_rdata_out(rdata), .diag_done_in(diag), .first_echo_polarity_in(pol),
    .cross_reflection_flag_in(crs), .master_mode_in(mst), .ref_clock_out_50m_in(c50),
    .second_link_led_in(led2), .wake_indication_in(wake), .management_interrupt_in(mint),
    .ref_clock_out_25m_in(c25), .first_led_general_output_in(led1),
    .first_led_pin_control_in(pctl), .receive_disabled_in(rxd), .settled_state_in(stl),
    .idle_wake_state_in(iwk), .idle_wait_state_in(iwt), .idle_hold_state_in(ihd),
    .idle_refresh_start_in(rfs), .second_pin_out(sp), .ref_clock_pin_out(rp),
    .ref_clock_pin_oe_out(roe), .mac_pad_series_termination_out(term),
    .ref_clock_out_disable_out(cko), .rmii_rx_clk_sel_out(rsel), .freeze_all_loops_out(fal),
    .mse_check_bypass_out(mse), .settled_freeze_out(sfz), .refresh_freeze_out(rfz),
    .wait_loop_freeze_out(wfz));
  always #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task automatic wrr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk_in);
    wr = 0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_in);
    addr = a;
    rd = 1;
    @(negedge clk_in);
    rd = 0;
    cmp(rdata, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_clock_pin();
    rdc(16'h0308, 16'h0000);
    cmp({15'h0, roe}, 16'h0001);
    wrr(16'h0302, 16'hffff);
    rdc(16'h0302, 16'hc047);
    led1 = 1;
    pctl = 1;
    wrr(16'h0302, 16'h4040);
    tick(1);
    cmp({13'h0, term, cko}, 16'h0003);
    cmp({14'h0, rp, roe}, 16'h0003);
    rdc(16'h0308, 16'h0001);
    c25 = 1;
    wrr(16'h0302, 16'h0000);
    tick(1);
    cmp({12'h0, term, rp, roe}, 16'h0003);
    rdc(16'h0308, 16'h0000);
  endtask
  task automatic t_second_pin();
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 2; p++) begin
        oh = (k == 0) ? 4'h1 : (k == 1) ? 4'h2 : (k == 2) ? 4'h4 : (k == 4) ? 4'h8 : 4'h0;
        {mint, wake, led2, c50} = p ? ~oh : oh;
        wrr(16'h0302, {13'h0, 3'(k)});
        tick(1);
        cmp({15'h0, sp}, (k == 6) ? 16'h1 : {15'h0, oh != 0 && p == 0});
      end
    end
    mst = 0;
    c50 = 1;
    wrr(16'h0302, 16'h0000);
    tick(1);
    cmp({15'h0, sp}, 16'h0000);
  endtask
  task automatic t_spare();
    {rxd, iwk, stl, iwt} = 4'hf;
    wrr(16'h0308, 16'h8477);
    rdc(16'h0308, 16'h8474);
    cmp({6'h0, rsel, fal, mse, sfz, wfz}, 16'h03e1);
    {rxd, iwk, stl, iwt} = 4'h0;
    tick(2);
    cmp({6'h0, rsel, fal, mse, sfz, wfz}, 16'h0200);
  endtask
  task automatic t_echo();
    for (int k = 0; k < 2; k++) begin
      {pol, crs} = k ? 2'b01 : 2'b10;
      @(negedge clk_in);
      diag = 1;
      @(negedge clk_in);
      diag = 0;
      rdc(16'h018a, k ? 16'h0020 : 16'h0800);
    end
    wrr(16'h018a, 16'hffff);
    rdc(16'h018a, 16'h0020);
    rdc(16'h0189, 16'h0000);
  endtask
  task automatic t_count();
    ihd = 1;
    for (int s = 0; s < 3; s++) begin
      wrr(16'h0308, (s == 1) ? 16'h0180 : 16'h0080);
      @(negedge clk_in);
      rfs = 1;
      @(negedge clk_in);
      rfs = 0;
      tick(1);
      n = 0;
      while (rfz === 1'b1 && n < 100) begin
        if (s == 2 && n == 5) begin
          wrr(16'h0308, 16'h0000);
          tick(1);
        end
        @(negedge clk_in);
        n++;
      end
      if (n == 100) begin
        $display("unexpected at %0t: got %h want %h", $time, rfz, 1'b0);
        n_mismatch++;
        give_verdict();
      end
      cmp(16'(n), (s == 2) ? 16'd6 : (s == 1) ? 16'd30 : 16'd20);
    end
  endtask
  initial begin
    tick(20);
    reset_in = 0;
    t_clock_pin();
    t_second_pin();
    t_spare();
    t_echo();
    t_count();
    give_verdict();
  end
endmodule
`default_nettype wire
